// ===== design/rst_seq_pkg.sv
// Constants and types shared by the reset and start-up sequencer.
package rst_seq_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int EXT_FILTER_NS = 200;
	localparam int EXT_FILTER_CYC = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOR_MIN_NS = 200;
	localparam int BOR_MIN_CYC = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RC_PERIOD_NS = 1000;
	localparam int RC_DIV = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OST_CYCLES = 1024;
	localparam int DLY_W = 20;
	localparam int FILT_W = 8;
	localparam int DIV_W = 8;
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h2;
	localparam int RI_BIT = 4;
	localparam int TO_BIT = 3;
	localparam int PD_BIT = 2;
	localparam int POR_BIT = 1;
	localparam int BOR_BIT = 0;
	localparam logic [DATA_W-1:0] FLAGS_WR_MASK = 8'h13;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h1C;
	localparam int CFG_POWER_UP_TIMER_BIT = 0;
	localparam int CFG_BOR_BIT = 1;
	localparam int CFG_OSC_LSB = 2;
	localparam int CFG_PLL_BIT = 4;
	localparam logic [DATA_W-1:0] CFG_RESET = 8'h03;
	localparam logic [DATA_W-1:0] CFG_MASK = 8'h1F;
	localparam logic [1:0] OSC_RC = 2'h0;
	localparam logic [3:0] CAUSE_NONE = 4'h0;
	localparam logic [3:0] CAUSE_POR = 4'h1;
	localparam logic [3:0] CAUSE_EXT_RUN = 4'h2;
	localparam logic [3:0] CAUSE_EXT_SLEEP = 4'h3;
	localparam logic [3:0] CAUSE_WDT = 4'h4;
	localparam logic [3:0] CAUSE_BOR = 4'h5;
	localparam logic [3:0] CAUSE_INSTR = 4'h6;
	localparam logic [3:0] CAUSE_STK_FULL = 4'h7;
	localparam logic [3:0] CAUSE_STK_UNDER = 4'h8;
	localparam logic [3:0] CAUSE_WDT_WAKE = 4'h9;
	typedef enum logic [8:0] {
		S_OFF = 9'h001,
		S_POWER_UP_TIMER = 9'h002,
		S_OST = 9'h004,
		S_PLL = 9'h008,
		S_HOLD = 9'h010,
		S_RUN = 9'h020,
		S_SLEEP = 9'h040,
		S_BOR = 9'h080,
		S_SWRST = 9'h100
	} seq_state_t;
endpackage

// ===== design/pin_filter.sv
// Two-flop synchroniser followed by a stability filter for one pin.
`timescale 1ns/1ps
module pin_filter #(
	parameter int STABLE = 1,
	parameter logic INIT = 1'b0
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic pin_i,
	output logic level_o
);
	import rst_seq_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic level;
		logic [FILT_W-1:0] cnt;
	} filt_t;

	filt_t st_reg;
	filt_t st_next;

	// A change reaches the output only after it has stood STABLE cycles.
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin_i;
		st_next.s2 = st_reg.s1;
		if (st_reg.s2 == st_reg.level) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt == FILT_W'(STABLE - 1)) begin
			st_next.level = st_reg.s2;
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + FILT_W'(1);
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '{s1: INIT, s2: INIT, level: INIT, cnt: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_o = st_reg.level;
endmodule

// ===== design/delay_counter.sv
// Restartable tick counter that flags when a target count is reached.
`timescale 1ns/1ps
module delay_counter (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [rst_seq_pkg::DLY_W-1:0] target_i,
	output logic done_o
);
	import rst_seq_pkg::*;

	typedef struct packed {
		logic [DLY_W-1:0] cnt;
		logic done;
	} dly_t;

	dly_t st_reg;
	dly_t st_next;

	always_comb begin
		st_next = st_reg;
		if (clear_i) begin
			st_next.cnt = '0;
			st_next.done = 1'b0;
		end else if (!st_reg.done && tick_i) begin
			st_next.cnt = st_reg.cnt + DLY_W'(1);
			st_next.done = (st_next.cnt == target_i);
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done_o = st_reg.done;
endmodule

// ===== design/reset_and_startup_sequencer.sv
// Reset source arbitration, start-up time-outs and reset status flags.
//
// Function
// - Recognise eight distinct reset causes.
// - Forced-state registers reset; others untouched.
// - Watchdog wake from sleep resumes, no reset.
// - Status flags show a pattern per cause.
// - Reset pin filter rejects short glitches.
// - Reset pin is input only, never driven.
// - Supply rise makes a power-on reset.
// - Power-up timer on RC ticks holds reset.
// - Configuration bit enables the power-up timer.
// - Oscillator start-up waits 1024 oscillator cycles.
// - Start-up count only crystal modes, power-on, wake.
// - PLL lock delay follows start-up after power-on.
// - Configuration bit enables brown-out reset.
// - Brown-out needs low supply for minimum time.
// - Stay in brown-out, then power-up timer.
// - Brown-out during power-up timer restarts it.
// - Power-on, then power-up timer, then start-up.
// - RC mode without timer has no time-out; the PLL bit still adds the PLL lock delay.
// - Time-outs ignore pin; release starts immediately.
// - Power-on flag cleared, software sets it.
// - Brown-out flag cleared, firmware sets it.
// - Watchdog clears time-out flag; sleep clears power-down.
// - Reset instruction clears its flag, else one.
`timescale 1ns/1ps
module reset_and_startup_sequencer #(
	parameter int POWER_UP_TIMER_TIME_US = 64,
	parameter int PLL_LOCK_TIME_US = 2000
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic supply_ok_i,
	input wire logic brownout_low_i,
	input wire logic ext_reset_pin_n_i,
	input wire logic osc_input_pin_i,
	input wire logic watchdog_timeout_i,
	input wire logic wake_i,
	input wire logic sleep_exec_i,
	input wire logic clear_wdt_i,
	input wire logic reset_instr_i,
	input wire logic stack_full_i,
	input wire logic stack_underflow_i,
	input wire logic [rst_seq_pkg::ADDR_W-1:0] addr_i,
	input wire logic [rst_seq_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [rst_seq_pkg::DATA_W-1:0] rdata_o,
	output logic core_reset_n_o,
	output logic core_stall_o,
	output logic ext_reset_pin_oe_o
);
	import rst_seq_pkg::*;

	localparam int POWER_UP_TIMER_TICKS = POWER_UP_TIMER_TIME_US * NS_PER_US / RC_PERIOD_NS;
	localparam int PLL_TICKS = PLL_LOCK_TIME_US * NS_PER_US / RC_PERIOD_NS;

	typedef struct packed {
		seq_state_t state;
		logic fresh;
		logic seq_por;
		logic seq_wake;
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] rdata;
		logic [3:0] cause;
		logic [DIV_W-1:0] div;
		logic rc_tick;
		logic osc_prev;
		logic osc_tick;
		logic core_rst_n;
		logic stall;
		logic pin_oe;
	} seq_t;

	seq_t st_reg;
	seq_t st_next;

	logic supply_ok;
	logic bor_low;
	logic ext_pin_s;
	logic osc_s;
	logic ext_low;
	logic power_up_timer_on;
	logic bor_on;
	logic pll_on;
	logic xtal;
	logic bor_trip;
	logic rc_clear;
	logic ost_clear;
	logic rc_done;
	logic ost_done;
	logic [DLY_W-1:0] rc_target;
	seq_state_t por_path;
	seq_state_t after_power_up_timer;
	seq_state_t after_ost;
	seq_state_t wake_path;

	pin_filter #(.STABLE(1), .INIT(1'b0)) supply_filt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(supply_ok_i),
		.level_o(supply_ok)
	);

	pin_filter #(.STABLE(BOR_MIN_CYC), .INIT(1'b0)) bor_filt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(brownout_low_i),
		.level_o(bor_low)
	);

	pin_filter #(.STABLE(EXT_FILTER_CYC), .INIT(1'b1)) ext_filt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(ext_reset_pin_n_i),
		.level_o(ext_pin_s)
	);

	pin_filter #(.STABLE(1), .INIT(1'b0)) osc_filt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.pin_i(osc_input_pin_i),
		.level_o(osc_s)
	);

	delay_counter rc_cnt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.clear_i(rc_clear),
		.tick_i(st_reg.rc_tick),
		.target_i(rc_target),
		.done_o(rc_done)
	);

	delay_counter ost_cnt (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.clear_i(ost_clear),
		.tick_i(st_reg.osc_tick),
		.target_i(DLY_W'(OST_CYCLES)),
		.done_o(ost_done)
	);

	assign ext_low = ~ext_pin_s;
	assign power_up_timer_on = st_reg.cfg[CFG_POWER_UP_TIMER_BIT];
	assign bor_on = st_reg.cfg[CFG_BOR_BIT];
	assign pll_on = st_reg.cfg[CFG_PLL_BIT];
	assign xtal = st_reg.cfg[CFG_OSC_LSB+:2] != OSC_RC;
	assign bor_trip = bor_on & bor_low;
	assign rc_clear = st_reg.fresh | ~(st_reg.state inside {S_POWER_UP_TIMER, S_PLL});
	assign ost_clear = st_reg.fresh | (st_reg.state != S_OST);
	assign rc_target = (st_reg.state == S_PLL) ? DLY_W'(PLL_TICKS) : DLY_W'(POWER_UP_TIMER_TICKS);
	// Power-up order: power-up timer, start-up count, then PLL lock.
	assign por_path = xtal ? S_OST : (pll_on ? S_PLL : S_HOLD);
	assign after_power_up_timer = st_reg.seq_por ? por_path : S_HOLD;
	assign after_ost = (st_reg.seq_por && pll_on) ? S_PLL : S_HOLD;
	assign wake_path = xtal ? S_OST : S_RUN;

	always_comb begin
		st_next = st_reg;
		st_next.fresh = 1'b0;
		st_next.rdata = '0;
		st_next.rc_tick = (st_reg.div == DIV_W'(RC_DIV - 1));
		st_next.div = st_next.rc_tick ? '0 : st_reg.div + DIV_W'(1);
		st_next.osc_prev = osc_s;
		st_next.osc_tick = osc_s & ~st_reg.osc_prev;
		if (wr_i && addr_i == ADDR_FLAGS) begin
			st_next.flags = (st_reg.flags & ~FLAGS_WR_MASK) | (wdata_i & FLAGS_WR_MASK);
		end
		if (wr_i && addr_i == ADDR_CFG) begin
			st_next.cfg = wdata_i & CFG_MASK;
		end
		if (rd_i) begin
			case (addr_i)
				ADDR_FLAGS: st_next.rdata = st_reg.flags;
				ADDR_CFG: st_next.rdata = st_reg.cfg;
				ADDR_STAT: st_next.rdata = {3'h0, st_reg.core_rst_n, st_reg.cause};
				default: st_next.rdata = '0;
			endcase
		end
		if (clear_wdt_i) begin
			st_next.flags[TO_BIT] = 1'b1;
			st_next.flags[PD_BIT] = 1'b1;
		end
		if (!supply_ok) begin
			st_next.state = S_OFF;
		end else if (st_reg.state == S_OFF) begin
			st_next.flags[RI_BIT] = 1'b1;
			st_next.flags[TO_BIT] = 1'b1;
			st_next.flags[PD_BIT] = 1'b1;
			st_next.flags[POR_BIT] = 1'b0;
			st_next.flags[BOR_BIT] = bor_on;
			st_next.cause = CAUSE_POR;
			st_next.seq_por = 1'b1;
			st_next.seq_wake = 1'b0;
			st_next.state = power_up_timer_on ? S_POWER_UP_TIMER : por_path;
		end else if (bor_trip && st_reg.state != S_BOR) begin
			st_next.state = S_BOR;
			st_next.cause = CAUSE_BOR;
			st_next.flags[RI_BIT] = 1'b1;
			st_next.flags[TO_BIT] = 1'b1;
			st_next.flags[PD_BIT] = 1'b1;
			st_next.flags[BOR_BIT] = 1'b0;
			st_next.seq_por = 1'b0;
			st_next.seq_wake = 1'b0;
		end else begin
			case (st_reg.state)
				S_BOR: begin
					st_next.flags[BOR_BIT] = 1'b0;
					if (!bor_trip) begin
						st_next.state = power_up_timer_on ? S_POWER_UP_TIMER : S_HOLD;
					end
				end
				S_POWER_UP_TIMER: begin
					if (!st_reg.fresh && rc_done) begin
						st_next.state = after_power_up_timer;
					end
				end
				S_OST: begin
					if (st_reg.seq_wake && ext_low) begin
						st_next.state = S_HOLD;
						st_next.cause = CAUSE_EXT_SLEEP;
						st_next.seq_wake = 1'b0;
					end else if (!st_reg.fresh && ost_done) begin
						st_next.state = st_reg.seq_wake ? S_RUN : after_ost;
						st_next.seq_wake = 1'b0;
					end
				end
				S_PLL: begin
					if (!st_reg.fresh && rc_done) begin
						st_next.state = S_HOLD;
					end
				end
				S_HOLD: begin
					if (!ext_low) begin
						st_next.state = S_RUN;
					end
				end
				S_SWRST: begin
					st_next.state = S_HOLD;
				end
				S_RUN: begin
					if (ext_low) begin
						st_next.state = S_HOLD;
						st_next.cause = CAUSE_EXT_RUN;
					end else if (watchdog_timeout_i) begin
						st_next.state = S_SWRST;
						st_next.cause = CAUSE_WDT;
						st_next.flags[TO_BIT] = 1'b0;
					end else if (reset_instr_i) begin
						st_next.state = S_SWRST;
						st_next.cause = CAUSE_INSTR;
						st_next.flags[RI_BIT] = 1'b0;
					end else if (stack_full_i) begin
						st_next.state = S_SWRST;
						st_next.cause = CAUSE_STK_FULL;
					end else if (stack_underflow_i) begin
						st_next.state = S_SWRST;
						st_next.cause = CAUSE_STK_UNDER;
					end else if (sleep_exec_i) begin
						st_next.state = S_SLEEP;
						st_next.flags[PD_BIT] = 1'b0;
						st_next.flags[TO_BIT] = 1'b1;
					end
				end
				S_SLEEP: begin
					if (ext_low) begin
						st_next.state = S_HOLD;
						st_next.cause = CAUSE_EXT_SLEEP;
					end else if (watchdog_timeout_i || wake_i) begin
						if (watchdog_timeout_i) begin
							st_next.flags[TO_BIT] = 1'b0;
							st_next.cause = CAUSE_WDT_WAKE;
						end
						st_next.state = wake_path;
						st_next.seq_wake = xtal;
					end
				end
				default: begin
					st_next.state = S_OFF;
				end
			endcase
		end
		st_next.fresh = (st_next.state != st_reg.state);
		st_next.core_rst_n = (st_next.state inside {S_RUN, S_SLEEP}) ||
			(st_next.state == S_OST && st_next.seq_wake);
		st_next.stall = (st_next.state == S_OST) && st_next.seq_wake;
		st_next.pin_oe = 1'b0;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '{state: S_OFF, fresh: 1'b0, seq_por: 1'b0, seq_wake: 1'b0,
				flags: FLAGS_RESET, cfg: CFG_RESET, rdata: '0, cause: CAUSE_NONE,
				div: '0, rc_tick: 1'b0, osc_prev: 1'b0, osc_tick: 1'b0,
				core_rst_n: 1'b0, stall: 1'b0, pin_oe: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;
	assign core_reset_n_o = st_reg.core_rst_n;
	assign core_stall_o = st_reg.stall;
	assign ext_reset_pin_oe_o = st_reg.pin_oe;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	pin_input_a: assert property (
		!ext_reset_pin_oe_o
	) else $error("Reset pin output enable raised.");
	por_flags_a: assert property (
		(st_reg.state == S_OFF) && supply_ok |=>
			!st_reg.flags[POR_BIT] && st_reg.cause == CAUSE_POR && !core_reset_n_o
	) else $error("Power-on reset not recorded.");
	core_release_a: assert property (
		$rose(core_reset_n_o) |->
			($past(st_reg.state) == S_HOLD) && !$past(ext_low)
	) else $error("Core released before start-up finished.");
	power_up_timer_hold_a: assert property (
		(st_reg.state == S_POWER_UP_TIMER) |-> !core_reset_n_o && !core_stall_o
	) else $error("Core released during power-up timer.");
	no_timeout_a: assert property (
		(st_reg.state == S_OFF) && supply_ok && !power_up_timer_on && !xtal && !pll_on |=>
			st_reg.state == S_HOLD
	) else $error("Time-out applied in RC mode without timer.");
	ost_wait_a: assert property (
		(st_reg.state == S_OST) && !ost_done && supply_ok && !bor_trip &&
			!(st_reg.seq_wake && ext_low) |=> st_reg.state == S_OST
	) else $error("Start-up count left early.");
	bor_restart_a: assert property (
		(st_reg.state == S_POWER_UP_TIMER) && supply_ok && bor_trip |=>
			(st_reg.state == S_BOR) && !core_reset_n_o
	) else $error("Brown-out during power-up timer missed.");
	bor_flag_a: assert property (
		(st_reg.state == S_BOR) |-> !st_reg.flags[BOR_BIT] && st_reg.cause == CAUSE_BOR
	) else $error("Brown-out flag not clear.");
	wdt_flag_a: assert property (
		(st_reg.state == S_RUN) && watchdog_timeout_i && supply_ok && !bor_trip &&
			!ext_low |=> !st_reg.flags[TO_BIT] ##1 st_reg.state == S_HOLD
	) else $error("Watchdog reset not recorded.");
	instr_flag_a: assert property (
		(st_reg.state == S_RUN) && reset_instr_i && !watchdog_timeout_i &&
			supply_ok && !bor_trip && !ext_low |=>
			!st_reg.flags[RI_BIT] && !core_reset_n_o
	) else $error("Reset instruction not recorded.");
	rc_wake_a: assert property (
		(st_reg.state == S_SLEEP) && wake_i && !xtal && supply_ok && !bor_trip &&
			!ext_low |=> (st_reg.state == S_RUN) && core_reset_n_o
	) else $error("Wake in RC mode did not resume.");
	hold_release_a: assert property (
		(st_reg.state == S_HOLD) && !ext_low && supply_ok && !bor_trip |=>
			core_reset_n_o
	) else $error("Pin release did not start the core.");
	run_c: cover property ((st_reg.state == S_HOLD) ##1 (st_reg.state == S_RUN));
	bor_c: cover property ((st_reg.state == S_BOR) ##1 (st_reg.state == S_POWER_UP_TIMER));
	wake_ost_c: cover property (core_stall_o ##1 !core_stall_o && core_reset_n_o);
	swrst_c: cover property ((st_reg.state == S_SWRST) ##1 (st_reg.state == S_HOLD));
endmodule

// ===== testbench/board_model.sv
// Supply monitor, external reset pin and oscillator driving the sequencer.
`timescale 1ns/1ps
module board_model #(
	parameter int OSC_HALF_NS = 15
) (
	input wire logic clock_i,
	output logic supply_ok_o,
	output logic brownout_low_o,
	output logic ext_reset_pin_n_o,
	output logic osc_o
);
	// The oscillator swings only while the supply is up; its edges sit off the clock edges.
	initial begin
		supply_ok_o = 1'b0;
		brownout_low_o = 1'b0;
		ext_reset_pin_n_o = 1'b1;
		osc_o = 1'b0;
		#2;
		forever begin
			#(OSC_HALF_NS);
			osc_o = supply_ok_o ? ~osc_o : 1'b0;
		end
	end
	task automatic set_supply(input logic v);
		@(posedge clock_i);
		supply_ok_o <= v;
	endtask
	task automatic set_pin(input logic v);
		@(posedge clock_i);
		ext_reset_pin_n_o <= v;
	endtask
	task automatic pin_low(input int n);
		set_pin(1'b0);
		repeat (n) @(posedge clock_i);
		ext_reset_pin_n_o <= 1'b1;
	endtask
	task automatic set_low(input logic v);
		@(posedge clock_i);
		brownout_low_o <= v;
	endtask
	task automatic dip(input int n);
		set_low(1'b1);
		repeat (n) @(posedge clock_i);
		brownout_low_o <= 1'b0;
	endtask
endmodule

// ===== testbench/test_reset_and_startup_sequencer.sv
// Self-checking bench for the reset and start-up sequencer.
`timescale 1ns/1ps
module test_reset_and_startup_sequencer;
	import rst_seq_pkg::*;
	localparam int POWER_UP_TIMER_US = 4;
	localparam int PLL_US = 3;
	localparam int OSC_CLK = 3;
	localparam int EB [4] = '{0, 4, 5, 6};
	localparam logic [3:0] EC [4] = '{CAUSE_WDT, CAUSE_INSTR, CAUSE_STK_FULL, CAUSE_STK_UNDER};
	localparam logic [7:0] EF [4] = '{8'h17, 8'h0F, 8'h1F, 8'h1F};
	logic clock_i;
	logic nrst_i;
	logic supply_ok;
	logic brown_low;
	logic pin_n;
	logic osc;
	logic [6:0] ev;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [DATA_W-1:0] rdata;
	logic core_n;
	logic stall;
	logic pin_oe;
	logic low_seen;
	logic [7:0] d;
	logic [7:0] fl;
	int err_count;
	int n_tests;
	int n;
	int r;
	board_model board_model_inst (.clock_i(clock_i), .supply_ok_o(supply_ok),
		.brownout_low_o(brown_low), .ext_reset_pin_n_o(pin_n), .osc_o(osc));
	reset_and_startup_sequencer #(.POWER_UP_TIMER_TIME_US(POWER_UP_TIMER_US), .PLL_LOCK_TIME_US(PLL_US))
		reset_and_startup_sequencer_inst (.clock_i(clock_i), .nrst_i(nrst_i),
		.supply_ok_i(supply_ok), .brownout_low_i(brown_low), .ext_reset_pin_n_i(pin_n),
		.osc_input_pin_i(osc), .watchdog_timeout_i(ev[0]), .wake_i(ev[1]),
		.sleep_exec_i(ev[2]), .clear_wdt_i(ev[3]), .reset_instr_i(ev[4]),
		.stack_full_i(ev[5]), .stack_underflow_i(ev[6]), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .core_reset_n_o(core_n),
		.core_stall_o(stall), .ext_reset_pin_oe_o(pin_oe));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	function automatic int t_lo(logic [7:0] c);
		return (c[CFG_POWER_UP_TIMER_BIT] ? (POWER_UP_TIMER_US - 1) * RC_DIV : 0)
			+ (c[CFG_OSC_LSB+:2] != OSC_RC ? (OST_CYCLES - 2) * OSC_CLK : 0)
			+ (c[CFG_PLL_BIT] ? (PLL_US - 1) * RC_DIV : 0);
	endfunction
	function automatic int t_hi(logic [7:0] c);
		return t_lo(c) + (c[CFG_POWER_UP_TIMER_BIT] ? RC_DIV : 0) + (c[CFG_PLL_BIT] ? RC_DIV : 0) + 40;
	endfunction
	function automatic logic [7:0] f_wr(logic [7:0] cur, logic [7:0] w);
		return (cur & ~FLAGS_WR_MASK) | (w & FLAGS_WR_MASK);
	endfunction
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", s, exp, seen);
		end
	endtask
	task automatic wr_t(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clock_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clock_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		check(s, rdata, e);
	endtask
	task automatic pulse(input int b);
		@(posedge clock_i);
		ev <= 7'(1) << b;
		@(posedge clock_i);
		ev <= '0;
	endtask
	task automatic wait_for(input logic use_stall, input logic lvl, input int lim);
		#1;
		n = 0;
		while ((use_stall ? stall : core_n) !== lvl) begin
			@(posedge clock_i);
			#1;
			n++;
			if (n > lim) begin
				$display("mismatch wait_%0d expected %0b seen timeout", use_stall, lvl);
				err_count++;
				end_sim();
			end
		end
	endtask
	task automatic stays_high(input int lim);
		low_seen = 1'b0;
		repeat (lim) begin
			@(posedge clock_i);
			#1;
			if (core_n !== 1'b1)
				low_seen = 1'b1;
		end
	endtask
	task automatic power_up(input logic [7:0] c, input string s);
		wr_t(ADDR_CFG, c);
		board_model_inst.set_supply(1'b0);
		repeat (10) @(posedge clock_i);
		#1;
		check("supply_low", core_n, 1'b0);
		board_model_inst.set_supply(1'b1);
		wait_for(1'b0, 1'b1, t_hi(c));
		check("delay", n >= t_lo(c), 1'b1);
		rchk("por_cause", ADDR_STAT, {4'h1, CAUSE_POR});
		rchk("por_flags", ADDR_FLAGS, 8'h1C | {7'h0, c[CFG_BOR_BIT]});
		wr_t(ADDR_FLAGS, 8'h13);
		rchk("flags_set", ADDR_FLAGS, 8'h1F);
		$display("test %s done", s);
	endtask
	initial begin
		nrst_i = 1'b0;
		ev = '0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		err_count = 0;
		n_tests = 0;
		r = $urandom(69164);
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'b1;
		rchk("cfg_rst", ADDR_CFG, CFG_RESET);
		rchk("flags_rst", ADDR_FLAGS, FLAGS_RESET);
		power_up(CFG_RESET, "por");
		r = $urandom_range(1, 12);
		board_model_inst.dip(r);
		stays_high(40);
		check("bor_glitch", low_seen, 1'b0);
		board_model_inst.dip(40);
		#1;
		check("bor_low", core_n, 1'b0);
		wait_for(1'b0, 1'b1, t_hi(8'h01));
		check("bor_power_up_timer", n >= t_lo(8'h01), 1'b1);
		rchk("bor_cause", ADDR_STAT, {4'h1, CAUSE_BOR});
		rchk("bor_flags", ADDR_FLAGS, 8'h1E);
		board_model_inst.dip(40);
		repeat (100) @(posedge clock_i);
		board_model_inst.dip(40);
		wait_for(1'b0, 1'b1, t_hi(8'h01));
		check("bor_restart", n >= t_lo(8'h01), 1'b1);
		r = $urandom_range(1, 12);
		board_model_inst.pin_low(r);
		stays_high(40);
		check("pin_glitch", low_seen, 1'b0);
		board_model_inst.pin_low(40);
		#1;
		check("pin_low", core_n, 1'b0);
		check("pin_oe", pin_oe, 1'b0);
		wait_for(1'b0, 1'b1, 30);
		rchk("pin_cause", ADDR_STAT, {4'h1, CAUSE_EXT_RUN});
		$display("test brownout_pin done");
		for (int i = 0; i < 4; i++) begin
			wr_t(ADDR_FLAGS, 8'h13);
			pulse(3);
			pulse(EB[i]);
			wait_for(1'b0, 1'b0, 3);
			check("int_oe", pin_oe, 1'b0);
			wait_for(1'b0, 1'b1, 10);
			rchk("ev_cause", ADDR_STAT, {4'h1, EC[i]});
			rchk("ev_flags", ADDR_FLAGS, EF[i]);
		end
		pulse(2);
		rchk("sleep_flags", ADDR_FLAGS, 8'h1B);
		pulse(0);
		stays_high(20);
		check("wdt_wake", low_seen, 1'b0);
		rchk("wake_cause", ADDR_STAT, {4'h1, CAUSE_WDT_WAKE});
		pulse(2);
		pulse(1);
		#1;
		check("rc_wake", {stall, core_n}, 2'b01);
		pulse(2);
		board_model_inst.pin_low(40);
		#1;
		check("slp_pin_low", core_n, 1'b0);
		wait_for(1'b0, 1'b1, 30);
		rchk("slp_pin_cause", ADDR_STAT, {4'h1, CAUSE_EXT_SLEEP});
		$display("test events done");
		wr_t(ADDR_FLAGS, 8'h13);
		pulse(3);
		fl = 8'h1F;
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr_t(ADDR_FLAGS, d);
			fl = f_wr(fl, d);
			rchk("flags_rw", ADDR_FLAGS, fl);
			wr_t(2'h3, d);
			rchk("unmapped", 2'h3, 8'h00);
		end
		$display("test regs done");
		for (int m = 1; m < 4; m++) begin
			d = {3'h0, m == 2, 2'(m), 2'h1};
			power_up(d, "osc");
			pulse(2);
			pulse(1);
			wait_for(1'b1, 1'b1, 5);
			wait_for(1'b1, 1'b0, OST_CYCLES * OSC_CLK + 40);
			check("stall_len", n >= (OST_CYCLES - 2) * OSC_CLK, 1'b1);
		end
		power_up(8'h00, "rc_none");
		board_model_inst.dip(40);
		stays_high(40);
		check("bor_off", low_seen, 1'b0);
		wr_t(ADDR_CFG, CFG_RESET);
		board_model_inst.set_pin(1'b0);
		board_model_inst.set_supply(1'b0);
		repeat (10) @(posedge clock_i);
		board_model_inst.set_supply(1'b1);
		repeat (t_hi(CFG_RESET)) @(posedge clock_i);
		#1;
		check("pin_hold", core_n, 1'b0);
		board_model_inst.set_pin(1'b1);
		wait_for(1'b0, 1'b1, 30);
		check("pin_release", n >= EXT_FILTER_CYC, 1'b1);
		$display("test pin_hold done");
		@(posedge clock_i);
		#3;
		nrst_i = 1'b0;
		#1;
		check("async_rst", core_n, 1'b0);
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		wait_for(1'b0, 1'b1, t_hi(CFG_RESET));
		rchk("rst2_cause", ADDR_STAT, {4'h1, CAUSE_POR});
		$display("test async_reset done");
		end_sim();
	end
endmodule
